// ### bench/asram_host_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Pin protocol watch on the host ports
module asram_host_chk
  import asram_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire asram_req_s req,
  input wire logic reqReady,
  input wire logic rdValid,
  input wire logic [DATA_W-1:0] rdData,
  input wire asram_pins_s pins,
  input wire logic [DATA_W-1:0] dataIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Decoded pin states
  wire sel = !pins.primarySelectN && pins.secondarySelect;
  wire st = !pins.storeN;
  wire rdTake = reqValid && reqReady && !req.write;
  a_write_sel: assert property (st |-> sel && pins.dataOe)
    else $error("strobe unselected");
  a_addr_hold: assert property (st |-> $stable(pins.addr))
    else $error("addr moved");
  a_data_hold: assert property ($fell(st) |-> pins.dataOe && $stable(pins.dataOut))
    else $error("data dropped");
  a_strobe_len: assert property ($rose(st) |-> st [*6] ##1 !st)
    else $error("strobe length");
  a_gate_off: assert property (!pins.outGateN |-> !st && !pins.dataOe && sel)
    else $error("gate on in write");
  a_desel_idle: assert property (!sel |-> !st && pins.outGateN && !pins.dataOe)
    else $error("deselected active");
  a_read_due: assert property (rdTake |-> ##[9:10] rdValid)
    else $error("read late");
  a_rd_pulse: assert property (rdValid |=> !rdValid)
    else $error("rdValid long");
  a_rd_hold: assert property ($changed(rdData) |-> rdValid)
    else $error("rdData moved");
  c_write: cover property ($rose(st));
  c_read: cover property (rdTake);
  c_wait: cover property (reqValid && !reqReady);
endmodule : asram_host_chk
bind asram_host asram_host_chk chk (.clk, .rst, .reqValid, .req, .reqReady,
  .rdValid, .rdData, .pins, .dataIn);
`default_nettype wire

// ### bench/asram_mem.sv
`timescale 1ns/10ps
`default_nettype none
// Memory model; a floating bus shows the inverse of its last byte
module asram_mem
  import asram_pkg::*;
(
  input wire asram_pins_s p,
  output logic [DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] last = 8'h00;
  wire sel = !p.primarySelectN && p.secondarySelect;
  wire wr = sel && !p.storeN;
  wire rd = sel && p.storeN && !p.outGateN;
  // Byte lands on the first trailing control edge
  always @(negedge wr) mem[p.addr] = p.dataOut;
  always @(negedge rd) last = mem[p.addr];
  assign dq = rd ? mem[p.addr] : ~last;
endmodule : asram_mem
`default_nettype wire

// ### bench/tb_asram_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host against the memory model; read bytes matched from a queue
module tb_asram_host
  import asram_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  asram_req_s req = '0;
  logic reqReady, rdValid;
  logic [DATA_W-1:0] rdData, dq, dataIn;
  asram_pins_s pins;
  logic [DATA_W-1:0] expQ [$];
  logic [DATA_W-1:0] shadow [int];
  logic [ADDR_W-1:0] ad [8];
  logic [31:0] seed = 32'h000158eb;
  int errCount = 0;
  int checksDone = 0;
  always #5 clk = ~clk;
  // Shared data pins: host drive wins, else the model
  assign dataIn = pins.dataOe ? pins.dataOut : dq;
  asram_host uut (.clk, .rst, .reqValid, .req, .reqReady, .rdValid, .rdData,
    .pins, .dataIn);
  asram_mem mem (.p(pins), .dq);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      errCount++;
      $display("CHECK FAILED %0t byte %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Request held until taken; busy cycles just stretch it
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{w, a, d};
    do @(posedge clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    if (w) shadow[a] = d;
    else expQ.push_back(shadow[a]);
  endtask : xfer
  task automatic summarize();
    $display("errors %0d checks %0d", errCount, checksDone);
    if (errCount == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // Oldest note against each returned byte
  always @(posedge clk)
    if (rdValid === 1'b1) chk(rdData, expQ.pop_front());
  // Both address ends, random spots, one overwrite, reread
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      ad[i] = i == 0 ? '0 : i == 1 ? '1 : ADDR_W'(rnd());
      xfer(1'b1, ad[i], DATA_W'(rnd()));
    end
    xfer(1'b1, ad[0], DATA_W'(rnd()));
    for (int i = 0; i < 8; i++) xfer(1'b0, ad[i], '0);
    xfer(1'b0, ad[0], '0);
    repeat (20) @(posedge clk);
    // Mid-run reset while idle: pins park, ready drops, bytes survive
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(DATA_W'(reqReady), '0);
    chk(DATA_W'({pins.primarySelectN, pins.secondarySelect, pins.storeN}), 8'h05);
    chk(DATA_W'({pins.outGateN, pins.dataOe}), 8'h02);
    rst <= 1'b0;
    xfer(1'b0, ad[1], '0);
    repeat (20) @(posedge clk);
    chk(DATA_W'(expQ.size()), '0);
    summarize();
  end
  // Hang guard well past the expected run
  initial
  begin
    #20000;
    errCount++;
    summarize();
  end
endmodule : tb_asram_host
`default_nettype wire

// ### shared/asram_pkg.sv
package asram_pkg;
  // Array geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int DEPTH = 131072;
  // Device timing figures in ns
  localparam int CLK_NS = 10;
  localparam int T_CYCLE_NS = 70;
  localparam int T_ACCESS_NS = 70;
  localparam int T_WPULSE_NS = 55;
  localparam int T_DSETUP_NS = 30;
  localparam int T_TURN_NS = 25;
  // Cycle counts; minimums round up, access rounds up plus one cycle so data has settled
  localparam int WP_CYC = (T_WPULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DS_CYC = (T_DSETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int TURN_CYC = (T_TURN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(WP_CYC > DS_CYC ? WP_CYC : DS_CYC);
  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(TURN_CYC);

  // Pin bundle driven toward the memory
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic primarySelectN;
    logic secondarySelect;
    logic storeN;
    logic outGateN;
    logic [DATA_W-1:0] dataOut;
    logic dataOe;
  } asram_pins_s;

  // Host request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } asram_req_s;
endpackage : asram_pkg

// ### verilog/asram_host.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Write happens while store strobe low, primary select low, secondary high.
// - Address is set before a write and held for its whole length.
// - Data is captured at the first trailing control edge; hold data past it.
// - Read drives the byte when strobe high, gate low and chip selected.
module asram_host
  import asram_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire asram_req_s req,
  output logic reqReady,
  output logic rdValid,
  output logic [DATA_W-1:0] rdData,
  output asram_pins_s pins,
  input wire logic [DATA_W-1:0] dataIn
);
  // One-hot sequencer states; a stray code falls back to idle
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WSET = 6'h02,
    ST_WPULSE = 6'h04,
    ST_WHOLD = 6'h08,
    ST_READ = 6'h10,
    ST_TURN = 6'h20
  } asram_state_e;

  asram_state_e state;
  asram_state_e next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [DATA_W-1:0] syncData;
  logic cntDone;
  logic takeReq;
  logic takeWrite;
  logic takeRead;
  logic rdDone;
  logic next_sel;
  logic next_storeN;
  logic next_gateN;
  logic next_drive;
  logic next_ready;

  // Write states: host drives the data pins through all three
  function automatic logic inWrite(
    input asram_state_e s
  );
    inWrite = (s == ST_WSET) || (s == ST_WPULSE) || (s == ST_WHOLD);
  endfunction : inWrite

  // Access states hold both selects active; outside them the memory idles
  function automatic logic inAccess(
    input asram_state_e s
  );
    inAccess = inWrite(s) || (s == ST_READ);
  endfunction : inAccess

  // Readback passes two flops since the pins are outside our clock
  asram_sync2 u_sync (
    .clk(clk),
    .rst(rst),
    .din(dataIn),
    .dout(syncData)
  );

  // Request decode
  assign cntDone = (cnt == '0);
  assign takeReq = reqValid && reqReady;
  assign takeWrite = takeReq && req.write;
  assign takeRead = takeReq && !req.write;
  // Read window closes; byte is taken from the sync stage
  assign rdDone = (state == ST_READ) && cntDone;

  // Next pin levels; registered below so every pin leaves a flop
  assign next_sel = inAccess(next_state);
  // Strobe low only in the pulse; it rises first, so it is the trailing edge
  assign next_storeN = !(next_state == ST_WPULSE);
  // Gate high outside reads so the memory never fights our drive
  assign next_gateN = !(next_state == ST_READ);
  // Data held one cycle past the strobe; costs a cycle, buys hold margin
  assign next_drive = inWrite(next_state);
  // Ready drops on the take edge so a held request is not taken twice
  assign next_ready = (next_state == ST_IDLE) && !takeReq;

  // Sequencer; counts meet the 70 ns cycle minimum (write selected 80 ns, read 90 ns)
  always_comb
  begin
    next_state = state;
    // Counter runs down to zero and rests there
    next_cnt = cntDone ? cnt : cnt - 4'h1;
    case (state)
      ST_IDLE:
      begin
        // Write opens with a setup cycle; address is fixed from here
        if (takeWrite)
        begin
          next_state = ST_WSET;
          next_cnt = '0;
        end
        else if (takeRead)
        begin
          next_state = ST_READ;
          next_cnt = RD_CNT;
        end
      end
      ST_WSET:
      begin
        // Load minus one: the pulse state also spends its zero cycle
        next_state = ST_WPULSE;
        next_cnt = WP_CNT - 4'h1;
      end
      ST_WPULSE:
      begin
        // Pulse long enough for width and data setup together
        if (cntDone)
        begin
          next_state = ST_WHOLD;
        end
      end
      ST_WHOLD:
      begin
        // One hold cycle: strobe high, selects and data still on
        next_state = ST_TURN;
        next_cnt = TURN_CNT;
      end
      ST_READ:
      begin
        // Window spans access time plus the two sync flops
        if (cntDone)
        begin
          next_state = ST_TURN;
          next_cnt = TURN_CNT;
        end
      end
      ST_TURN:
      begin
        // Deselected gap lets the memory drivers float first
        if (cntDone)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        // Illegal code recovers to idle
        next_state = ST_IDLE;
        next_cnt = '0;
      end
    endcase
  end

  // State and counter registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      cnt <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Pin drive; selects asserted only in access states, deselect = standby
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Deselected from reset so the memory sits in standby
      pins.addr <= '0;
      pins.primarySelectN <= 1'b1;
      pins.secondarySelect <= 1'b0;
      pins.storeN <= 1'b1;
      pins.outGateN <= 1'b1;
      pins.dataOut <= '0;
      pins.dataOe <= 1'b0;
    end
    else
    begin
      if (takeReq)
      begin
        pins.addr <= req.addr;
        pins.dataOut <= req.data;
      end
      // Selects move together; address loads on the same edge they assert
      pins.primarySelectN <= !next_sel;
      pins.secondarySelect <= next_sel;
      pins.storeN <= next_storeN;
      pins.outGateN <= next_gateN;
      pins.dataOe <= next_drive;
    end
  end

  // Handshake and read return
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reqReady <= 1'b0;
      rdValid <= 1'b0;
      rdData <= '0;
    end
    else
    begin
      reqReady <= next_ready;
      rdValid <= rdDone;
      // Byte holds between reads so a slow consumer can still pick it up
      if (rdDone)
      begin
        rdData <= syncData;
      end
    end
  end
endmodule : asram_host
`default_nettype wire

// ### verilog/asram_sync2.sv
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser for the data pins read back from the memory
module asram_sync2
  import asram_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout
);
  logic [DATA_W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : asram_sync2
`default_nettype wire
